/* File: tss_pkg.sv */
// Constants and types of the trigger step sequencer
//
// Contract
// - Trigger input and output edges are each selectable rising or falling per channel.
// - After reset the trigger input is detected on its falling edge.
// - After reset the trigger output pulses with falling-edge polarity.
// - Per-channel external-trigger enable, reset off.
// - Per-channel table of 20 steps, 0-15 V and 0-5 s, reset to zero.
// - Any addressed table entry can be read back.
// - The index of the step run on the next trigger is visible.
// - Voltage-stepping enable per channel, reset off; off means triggers keep voltage, except triggers in shared step.
// - Per-channel end voltage 0-15 V, reset 0.
// - Disabling by command, heat or a protection trip loads the end voltage.
// - Measurement mode none, sync or auto per channel, reset auto.
// - Point count 1-20 per channel, reset 1.
// - Voltage-protection-trip enable per channel, reset on.
// - Dual-channel selector none, shared step or shared measure, reset none.
// - Selector none: channel controls only itself through its own enable.
// - Shared step: this channel's trigger steps both channels, no measurements.
// - Shared measure: both channels measure on trigger, neither steps.
// - Shared modes use the combined enable command, not the per-channel enable.
// - Combined command: one on/off, two on/off, both on/off.
// - Stepping channel keeps stepping after the measuring peer has stopped.
// - Measuring channel halts after point count until re-armed; stepping wraps on.
// - Re-arm restarts a set of point-count steps on later triggers.
// - Trigger output idles high for falling polarity, low for rising.
// - Per trigger: step if enabled, wait delay, measure if enabled, pulse output.
`default_nettype none

package tss_pkg;
  localparam int NUM_CH    = 2;
  localparam int NUM_STEPS = 20;
  localparam int IDX_W     = 5;
  localparam int VOLT_W    = 14;  // Millivolts
  localparam int DLY_W     = 19;  // Units of 10 us
  localparam int SET_W     = 16;

  localparam logic [VOLT_W-1:0] VOLT_MAX = 14'h3A98;   // 15000 mV
  localparam logic [DLY_W-1:0]  DLY_MAX  = 19'h7_A120; // 500000 x 10 us

  localparam int CLK_NS        = 10;
  localparam int TICK_NS       = 10000;
  localparam int TICK_CYC      = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRIG_PULSE_NS = 10000;
  localparam int PULSE_CYC     = (TRIG_PULSE_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    MEAS_NONE = 2'h0,
    MEAS_SYNC = 2'h1,
    MEAS_AUTO = 2'h2
  } tss_meas_e;

  typedef enum logic [1:0] {
    DUAL_NONE = 2'h0,
    DUAL_VOLT = 2'h1,
    DUAL_AUTO = 2'h2
  } tss_dual_e;

  typedef enum logic [3:0] {
    ITEM_EDGE_IN  = 4'h0,
    ITEM_EDGE_OUT = 4'h1,
    ITEM_EXT_EN   = 4'h2,
    ITEM_VOLT_EN  = 4'h3,
    ITEM_END_V    = 4'h4,
    ITEM_MEAS     = 4'h5,
    ITEM_STEP_POINT_COUNT   = 4'h6,
    ITEM_VPT      = 4'h7,
    ITEM_DUAL     = 4'h8
  } tss_item_e;

  typedef enum logic [2:0] {
    CHANNEL_ONE_ON     = 3'h0,
    CHANNEL_ONE_OFF    = 3'h1,
    CHANNEL_TWO_ON     = 3'h2,
    CHANNEL_TWO_OFF    = 3'h3,
    BOTH_CHANNELS_ON   = 3'h4,
    BOTH_CHANNELS_OFF  = 3'h5
  } tss_comb_e;

  typedef enum logic [1:0] {
    S_IDLE  = 2'h0,
    S_DELAY = 2'h1,
    S_MEAS  = 2'h2,
    S_PULSE = 2'h3
  } tss_state_e;

  typedef struct packed {
    logic                        edge_in_rise;
    logic                        edge_out_rise;
    logic                        ext_en;
    logic                        volt_en;
    logic                        voltage_protection_trip_enable;
    logic [VOLT_W-1:0]           end_v;
    tss_meas_e                   meas;
    logic [IDX_W-1:0]            step_point_count;
    tss_dual_e                   dual;
  } tss_cfg_s;

  localparam tss_cfg_s RST_CFG = '{
    edge_in_rise:                   1'b0,
    edge_out_rise:                  1'b0,
    ext_en:                         1'b0,
    volt_en:                        1'b0,
    voltage_protection_trip_enable: 1'b1,
    end_v:                          14'h0000,
    meas:                           MEAS_AUTO,
    step_point_count:               5'h01,
    dual:                           DUAL_NONE
  };
  localparam logic [IDX_W-1:0] RST_IDX = 5'h01;
endpackage : tss_pkg

`default_nettype wire

/* File: tss_edge_det.sv */
// Trigger input synchroniser and selectable edge detector
`default_nettype none

module tss_edge_det (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Pin and edge choice
  input  wire logic pin,
  input  wire logic rise_sel,
  // One-cycle detection
  output logic      hit
);
  logic       sync1_r;
  logic       sync2_r;
  logic       prev_r;
  logic [1:0] warm_r;

  always_ff @(posedge clk_sys) begin
    sync1_r <= pin;
    sync2_r <= sync1_r;
    prev_r  <= sync2_r;
  end

  // Ignore edges until the chain holds real pin history
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      warm_r <= 2'h0;
    end else if (warm_r != 2'h3) begin
      warm_r <= warm_r + 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hit <= 1'b0;
    end else begin
      hit <= (warm_r == 2'h3) && (rise_sel ? (sync2_r && !prev_r)
                                           : (!sync2_r && prev_r));
    end
  end
endmodule : tss_edge_det

`default_nettype wire

/* File: tss_top.sv */
// Two-channel external-trigger voltage-step sequencer
`default_nettype none

module tss_top #(
  parameter int STEPS     = tss_pkg::NUM_STEPS,
  parameter int TICK_CYC  = tss_pkg::TICK_CYC,
  parameter int PULSE_CYC = tss_pkg::PULSE_CYC
) (
  // Clock and reset
  input  wire logic                                    clk_sys,
  input  wire logic                                    rst,
  // Trigger pins
  input  wire logic [1:0]                              trig_in,
  output logic [1:0]                                   trig_out,
  // Setting writes
  input  wire logic                                    set_wr,
  input  wire logic                                    set_ch,
  input  wire tss_pkg::tss_item_e                      set_item,
  input  wire logic [tss_pkg::SET_W-1:0]               set_val,
  // Step table writes
  input  wire logic                                    tbl_wr,
  input  wire logic                                    tbl_ch,
  input  wire logic [tss_pkg::IDX_W-1:0]               tbl_idx,
  input  wire logic [tss_pkg::VOLT_W-1:0]              tbl_volt,
  input  wire logic [tss_pkg::DLY_W-1:0]               tbl_dly,
  // Step table readback
  input  wire logic                                    rd_ch,
  input  wire logic [tss_pkg::IDX_W-1:0]               rd_idx,
  output logic [tss_pkg::VOLT_W-1:0]                   rd_volt,
  output logic [tss_pkg::DLY_W-1:0]                    rd_dly,
  output logic                                         rd_ok,
  // Commands
  input  wire logic                                    comb_wr,
  input  wire tss_pkg::tss_comb_e                      combined_trigger_enable_cmd,
  input  wire logic [1:0]                              rearm,
  // Fault inputs
  input  wire logic                                    over_temp,
  input  wire logic [1:0]                              vpt_trip,
  input  wire logic [1:0]                              ilim_trip,
  // Channel status
  output logic [1:0][tss_pkg::VOLT_W-1:0]              vout_set,
  output logic [1:0]                                   meas_strobe,
  output logic [1:0]                                   trig_active,
  output logic [1:0][tss_pkg::IDX_W-1:0]               next_step
);
  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int PW = $clog2(PULSE_CYC + 1);
  localparam logic [tss_pkg::IDX_W-1:0] STEPS_I = tss_pkg::IDX_W'(STEPS);
  localparam logic [TW-1:0] TICK_LAST  = TW'(TICK_CYC - 1);
  localparam logic [PW-1:0] PULSE_LAST = PW'(PULSE_CYC - 1);

  tss_pkg::tss_cfg_s                cfg_r [2];
  logic [1:0]                       comb_en_r;
  logic [tss_pkg::VOLT_W-1:0]       vtbl_r [2][STEPS];
  logic [tss_pkg::DLY_W-1:0]        dtbl_r [2][STEPS];
  tss_pkg::tss_state_e              st_r [2];
  logic [1:0]                       halted_r;
  logic [1:0]                       do_meas_r;
  logic [tss_pkg::DLY_W-1:0]        dcnt_r [2];
  logic [PW-1:0]                    pcnt_r [2];
  logic [TW-1:0]                    tcnt_r;
  logic                             tick_r;

  logic [1:0]                       det;
  logic [1:0]                       en_eff;
  logic [1:0]                       en_rise;
  logic [1:0]                       peer;
  logic [1:0]                       start;
  logic [1:0]                       step_on;
  logic [1:0]                       meas_on;
  tss_pkg::tss_dual_e               drv [2];
  logic                             trip;

  function automatic logic idx_ok(input logic [tss_pkg::IDX_W-1:0] i);
    idx_ok = (i != '0) && (i <= STEPS_I);
  endfunction : idx_ok

  function automatic logic [tss_pkg::IDX_W-1:0] tix(input logic [tss_pkg::IDX_W-1:0] i);
    tix = i - 5'h01;
  endfunction : tix

  for (genvar g = 0; g < 2; g++) begin : g_det
    tss_edge_det u_det (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .pin      (trig_in[g]),
      .rise_sel (cfg_r[g].edge_in_rise),
      .hit      (det[g])
    );
  end

  assign trip = over_temp | ilim_trip[0] | ilim_trip[1]
              | (vpt_trip[0] & cfg_r[0].voltage_protection_trip_enable)
              | (vpt_trip[1] & cfg_r[1].voltage_protection_trip_enable);

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      en_eff[c]  = (cfg_r[c].dual == tss_pkg::DUAL_NONE) ? cfg_r[c].ext_en
                                                          : comb_en_r[c];
      en_rise[c] = en_eff[c] && !trig_active[c];
      peer[c]    = det[c ^ 1] && en_eff[c ^ 1] && (cfg_r[c ^ 1].dual != tss_pkg::DUAL_NONE);
      drv[c]     = det[c] ? cfg_r[c].dual : cfg_r[c ^ 1].dual;
      start[c]   = en_eff[c] && !halted_r[c] && (st_r[c] == tss_pkg::S_IDLE)
                   && (det[c] || peer[c]);
      step_on[c] = (drv[c] == tss_pkg::DUAL_VOLT)
                   || ((drv[c] == tss_pkg::DUAL_NONE) && cfg_r[c].volt_en);
      meas_on[c] = (drv[c] == tss_pkg::DUAL_AUTO)
                   || ((drv[c] == tss_pkg::DUAL_NONE) && cfg_r[c].meas != tss_pkg::MEAS_NONE);
    end
  end

  // Settings; a fault trip beats a same-cycle enable write for safety
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_r[0] <= tss_pkg::RST_CFG;
      cfg_r[1] <= tss_pkg::RST_CFG;
    end else begin
      if (set_wr) begin
        case (set_item)
          tss_pkg::ITEM_EDGE_IN: begin
            cfg_r[set_ch].edge_in_rise <= set_val[0];
          end
          tss_pkg::ITEM_EDGE_OUT: begin
            cfg_r[set_ch].edge_out_rise <= set_val[0];
          end
          tss_pkg::ITEM_EXT_EN: begin
            cfg_r[set_ch].ext_en <= set_val[0];
          end
          tss_pkg::ITEM_VOLT_EN: begin
            cfg_r[set_ch].volt_en <= set_val[0];
          end
          tss_pkg::ITEM_END_V: begin
            if (set_val[15:14] == 2'h0 && set_val[13:0] <= tss_pkg::VOLT_MAX) begin
              cfg_r[set_ch].end_v <= set_val[13:0];
            end
          end
          tss_pkg::ITEM_MEAS: begin
            if (set_val[1:0] != 2'h3) begin
              cfg_r[set_ch].meas <= tss_pkg::tss_meas_e'(set_val[1:0]);
            end
          end
          tss_pkg::ITEM_STEP_POINT_COUNT: begin
            if (set_val[15:5] == '0 && idx_ok(set_val[4:0])) begin
              cfg_r[set_ch].step_point_count <= set_val[4:0];
            end
          end
          tss_pkg::ITEM_VPT: begin
            cfg_r[set_ch].voltage_protection_trip_enable <= set_val[0];
          end
          tss_pkg::ITEM_DUAL: begin
            if (set_val[1:0] != 2'h3) begin
              cfg_r[set_ch].dual <= tss_pkg::tss_dual_e'(set_val[1:0]);
            end
          end
          default: begin
          end
        endcase
      end
      if (trip) begin
        cfg_r[0].ext_en <= 1'b0;
        cfg_r[1].ext_en <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || trip) begin
      comb_en_r <= 2'h0;
    end else if (comb_wr) begin
      case (combined_trigger_enable_cmd)
        tss_pkg::CHANNEL_ONE_ON:    comb_en_r[0] <= 1'b1;
        tss_pkg::CHANNEL_ONE_OFF:   comb_en_r[0] <= 1'b0;
        tss_pkg::CHANNEL_TWO_ON:    comb_en_r[1] <= 1'b1;
        tss_pkg::CHANNEL_TWO_OFF:   comb_en_r[1] <= 1'b0;
        tss_pkg::BOTH_CHANNELS_ON:  comb_en_r <= 2'h3;
        tss_pkg::BOTH_CHANNELS_OFF: comb_en_r <= 2'h0;
        default: begin
        end
      endcase
    end
  end

  // Out-of-range writes leave the entry untouched
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int c = 0; c < 2; c++) begin
        for (int s = 0; s < STEPS; s++) begin
          vtbl_r[c][s] <= '0;
          dtbl_r[c][s] <= '0;
        end
      end
    end else if (tbl_wr && idx_ok(tbl_idx) && tbl_volt <= tss_pkg::VOLT_MAX
                 && tbl_dly <= tss_pkg::DLY_MAX) begin
      vtbl_r[tbl_ch][tix(tbl_idx)] <= tbl_volt;
      dtbl_r[tbl_ch][tix(tbl_idx)] <= tbl_dly;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || !idx_ok(rd_idx)) begin
      rd_volt <= '0;
      rd_dly  <= '0;
      rd_ok   <= 1'b0;
    end else begin
      rd_volt <= vtbl_r[rd_ch][tix(rd_idx)];
      rd_dly  <= dtbl_r[rd_ch][tix(rd_idx)];
      rd_ok   <= 1'b1;
    end
  end

  // Shared 10 us tick for all step delays
  always_ff @(posedge clk_sys) begin
    if (rst || tcnt_r == TICK_LAST) begin
      tcnt_r <= '0;
      tick_r <= !rst;
    end else begin
      tcnt_r <= tcnt_r + TW'(1);
      tick_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int c = 0; c < 2; c++) begin
      if (rst) begin
        st_r[c]        <= tss_pkg::S_IDLE;
        next_step[c]   <= tss_pkg::RST_IDX;
        halted_r[c]    <= 1'b0;
        do_meas_r[c]   <= 1'b0;
        dcnt_r[c]      <= '0;
        pcnt_r[c]      <= '0;
        meas_strobe[c] <= 1'b0;
      end else if (!en_eff[c]) begin
        st_r[c]        <= tss_pkg::S_IDLE;
        meas_strobe[c] <= 1'b0;
      end else begin
        meas_strobe[c] <= 1'b0;
        pcnt_r[c]      <= '0;
        case (st_r[c])
          tss_pkg::S_IDLE: begin
            if (en_rise[c] || rearm[c]) begin
              next_step[c] <= tss_pkg::RST_IDX;
              halted_r[c]  <= 1'b0;
              st_r[c]      <= tss_pkg::S_PULSE;
            end else if (start[c]) begin
              do_meas_r[c] <= meas_on[c];
              dcnt_r[c]    <= dtbl_r[c][tix(next_step[c])];
              st_r[c]      <= tss_pkg::S_DELAY;
              if (next_step[c] >= cfg_r[c].step_point_count) begin
                next_step[c] <= tss_pkg::RST_IDX;
                halted_r[c]  <= meas_on[c];
              end else begin
                next_step[c] <= next_step[c] + 5'h01;
              end
            end
          end
          tss_pkg::S_DELAY: begin
            if (dcnt_r[c] == '0) begin
              st_r[c] <= do_meas_r[c] ? tss_pkg::S_MEAS : tss_pkg::S_PULSE;
            end else if (tick_r) begin
              dcnt_r[c] <= dcnt_r[c] - tss_pkg::DLY_W'(1);
            end
          end
          tss_pkg::S_MEAS: begin
            meas_strobe[c] <= 1'b1;
            st_r[c]        <= tss_pkg::S_PULSE;
          end
          tss_pkg::S_PULSE: begin
            if (pcnt_r[c] == PULSE_LAST) begin
              st_r[c] <= tss_pkg::S_IDLE;
            end else begin
              pcnt_r[c] <= pcnt_r[c] + PW'(1);
            end
          end
          default: begin
            st_r[c] <= tss_pkg::S_IDLE;
          end
        endcase
      end
    end
  end

  // Voltage follows the end value the whole time triggering is off
  always_ff @(posedge clk_sys) begin
    for (int c = 0; c < 2; c++) begin
      if (rst) begin
        vout_set[c] <= '0;
      end else if (!en_eff[c]) begin
        vout_set[c] <= cfg_r[c].end_v;
      end else if (start[c] && step_on[c]) begin
        vout_set[c] <= vtbl_r[c][tix(next_step[c])];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int c = 0; c < 2; c++) begin
      if (rst) begin
        trig_out[c]    <= !tss_pkg::RST_CFG.edge_out_rise;
        trig_active[c] <= 1'b0;
      end else begin
        trig_out[c]    <= !cfg_r[c].edge_out_rise ^ (st_r[c] == tss_pkg::S_PULSE);
        trig_active[c] <= en_eff[c];
      end
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_out_idle: assert property ((st_r[0] != tss_pkg::S_PULSE)
    |=> trig_out[0] == $past(!cfg_r[0].edge_out_rise))
    else $error("trigger out not at idle level");
  a_pulse_end: assert property ((st_r[0] == tss_pkg::S_PULSE)
    |-> ##[0:1000] (st_r[0] != tss_pkg::S_PULSE))
    else $error("trigger out pulse too long");
  a_end_load: assert property (!en_eff[0]
    |=> vout_set[0] == $past(cfg_r[0].end_v))
    else $error("end voltage not loaded");
  a_trip_off: assert property (trip
    |=> !cfg_r[0].ext_en && !cfg_r[1].ext_en && comb_en_r == 2'h0)
    else $error("trip left triggering enabled");
  a_hold_volt: assert property ((en_eff[0] && !(start[0] && step_on[0]))
    |=> $stable(vout_set[0]))
    else $error("voltage moved without a step");
  a_auto_nostep: assert property ((start[0] && !det[0] && !en_rise[0] && !rearm[0]
    && cfg_r[1].dual == tss_pkg::DUAL_AUTO) |=> $stable(vout_set[0]) && do_meas_r[0])
    else $error("shared measure stepped voltage");
  a_volt_nomeas: assert property ((start[0] && !det[0] && !en_rise[0] && !rearm[0]
    && cfg_r[1].dual == tss_pkg::DUAL_VOLT) |=> !do_meas_r[0])
    else $error("shared step took a measurement");
  a_step_point_count_ok: assert property (cfg_r[0].step_point_count != '0
    && cfg_r[0].step_point_count <= STEPS_I)
    else $error("point count out of range");
  a_rearm_idx: assert property ((rearm[0] && en_eff[0] && st_r[0] == tss_pkg::S_IDLE)
    |=> next_step[0] == tss_pkg::RST_IDX && !halted_r[0])
    else $error("rearm did not restart the set");
  a_halt_hold: assert property ((halted_r[0] && !rearm[0] && !en_rise[0])
    |=> halted_r[0] && $stable(next_step[0]))
    else $error("halted channel advanced");
  a_start_seq: assert property ((start[0] && !en_rise[0] && !rearm[0])
    |=> st_r[0] == tss_pkg::S_DELAY ##1 st_r[0] != tss_pkg::S_IDLE)
    else $error("trigger did not start delay");
  a_step_wrap: assert property ((start[0] && !en_rise[0] && !rearm[0]
    && next_step[0] >= cfg_r[0].step_point_count) |=> next_step[0] == tss_pkg::RST_IDX)
    else $error("step index did not wrap");

  c_step: cover property (start[0] && step_on[0]);
  c_halt: cover property ($rose(halted_r[0]));
  c_shared: cover property (start[1] && det[0] && !det[1]);
  c_trip: cover property (trip && trig_active[0]);
endmodule : tss_top

`default_nettype wire

/* File: tss_ext_eq.sv */
// External test equipment model driving the trigger pins
`default_nettype none

module tss_ext_eq (
  // Clock
  input  wire logic            clk_sys,
  // Bench control
  input  wire logic [1:0]      fire,
  input  wire logic [1:0]      in_rise,
  input  wire logic [1:0]      out_rise,
  // Trigger pins
  input  wire logic [1:0]      trig_out,
  output logic [1:0]           trig_in,
  output logic [1:0][7:0]      seen
);
  logic [1:0][2:0] hold_r;
  logic [1:0]      out_q;

  initial begin
    hold_r = '0;
    seen   = '0;
    out_q  = 2'b11;
  end

  // Pulse held six cycles so the edge survives the pin synchroniser
  always @(posedge clk_sys) begin
    for (int c = 0; c < 2; c++) begin
      if (fire[c]) begin
        hold_r[c] <= 3'h6;
      end else if (hold_r[c] != 3'h0) begin
        hold_r[c] <= hold_r[c] - 3'h1;
      end
      if (trig_out[c] != out_q[c] && trig_out[c] == out_rise[c]) begin
        seen[c] <= seen[c] + 8'h01;
      end
    end
    out_q <= trig_out;
  end

  // Active level only while held; idle is the opposite level
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      trig_in[c] = (hold_r[c] != 3'h0) ? in_rise[c] : ~in_rise[c];
    end
  end
endmodule : tss_ext_eq

`default_nettype wire

/* File: testbench.sv */
// Self-checking bench of the trigger step sequencer
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 4;
  localparam int PC = 4;
  logic               clk_sys = 1'b0;
  logic               rst = 1'b1;
  logic [1:0]         trig_in, trig_out, fire, in_rise, out_rise, rearm, vpt_trip, ilim_trip;
  logic               set_wr, set_ch, tbl_wr, tbl_ch, rd_ch, comb_wr, over_temp, rd_ok, e2;
  tss_pkg::tss_item_e set_item;
  tss_pkg::tss_comb_e cmd;
  logic [15:0]        set_val;
  logic [4:0]         tbl_idx, rd_idx;
  logic [13:0]        tbl_volt, rd_volt;
  logic [18:0]        tbl_dly, rd_dly;
  logic [1:0][13:0]   vout_set;
  logic [1:0]         meas_strobe, trig_active;
  logic [1:0][4:0]    next_step;
  logic [1:0][7:0]    seen;
  logic [13:0]        tv [2][21];
  logic [18:0]        td [2][21];
  logic [31:0]        rs = 32'h0000_76d1;
  int                 mismatches = 0;
  int                 total_checks = 0;
  int                 cyc = 0;
  int                 ms0 = 0;
  int                 m;

  tss_top #(.TICK_CYC(TK), .PULSE_CYC(PC)) dut (.clk_sys(clk_sys), .rst(rst),
    .trig_in(trig_in), .trig_out(trig_out), .set_wr(set_wr), .set_ch(set_ch),
    .set_item(set_item), .set_val(set_val), .tbl_wr(tbl_wr), .tbl_ch(tbl_ch),
    .tbl_idx(tbl_idx), .tbl_volt(tbl_volt), .tbl_dly(tbl_dly), .rd_ch(rd_ch),
    .rd_idx(rd_idx), .rd_volt(rd_volt), .rd_dly(rd_dly), .rd_ok(rd_ok), .comb_wr(comb_wr),
    .combined_trigger_enable_cmd(cmd), .rearm(rearm), .over_temp(over_temp),
    .vpt_trip(vpt_trip), .ilim_trip(ilim_trip), .vout_set(vout_set),
    .meas_strobe(meas_strobe), .trig_active(trig_active), .next_step(next_step));

  tss_ext_eq eq (.clk_sys(clk_sys), .fire(fire), .in_rise(in_rise), .out_rise(out_rise),
    .trig_out(trig_out), .trig_in(trig_in), .seen(seen));

  always #5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc++;
    if (meas_strobe[0] === 1'b1) ms0++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : xs

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic cw(int n);
    repeat (n) @(negedge clk_sys);
  endtask : cw

  task automatic set(logic ch, tss_pkg::tss_item_e it, logic [15:0] v);
    @(negedge clk_sys);
    set_wr = 1'b1;
    set_ch = ch;
    set_item = it;
    set_val = v;
    @(negedge clk_sys);
    set_wr = 1'b0;
  endtask : set

  task automatic twr(logic ch, logic [4:0] i, logic [13:0] v, logic [18:0] d);
    @(negedge clk_sys);
    {tbl_wr, tbl_ch, tbl_idx, tbl_volt, tbl_dly} = {1'b1, ch, i, v, d};
    @(negedge clk_sys);
    tbl_wr = 1'b0;
    if (i >= 1 && i <= 20 && v <= 14'h3A98 && d <= 19'h7_A120) begin
      tv[ch][i] = v;
      td[ch][i] = d;
    end
  endtask : twr

  task automatic rchk(logic ch, logic [4:0] i, logic ok);
    @(negedge clk_sys);
    {rd_ch, rd_idx} = {ch, i};
    @(negedge clk_sys);
    chk("rd_volt", rd_volt, ok ? tv[ch][i] : 14'h0000);
    chk("rd_dly", rd_dly, ok ? td[ch][i] : 19'h0_0000);
    chk("rd_ok", rd_ok, ok);
  endtask : rchk

  // Wait bounded for a handshake pulse, or for its absence
  task automatic wp(int c, logic [7:0] n, logic exp);
    for (int k = 0; k < 300 && seen[c] == n; k++) @(negedge clk_sys);
    chk("out_pulse", seen[c] != n, exp);
    cw(PC + 4);
  endtask : wp

  task automatic trig(int c, logic exp);
    logic [7:0] n;
    n = seen[c];
    @(negedge clk_sys);
    fire[c] = 1'b1;
    @(negedge clk_sys);
    fire[c] = 1'b0;
    wp(c, n, exp);
  endtask : trig

  task automatic pulse_rearm();
    logic [7:0] n;
    n = seen[0];
    @(negedge clk_sys);
    rearm[0] = 1'b1;
    @(negedge clk_sys);
    rearm[0] = 1'b0;
    wp(0, n, 1'b1);
    chk("rearm_step", next_step[0], 5'h01);
  endtask : pulse_rearm

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  initial begin
    {fire, in_rise, out_rise, rearm, vpt_trip, ilim_trip} = '0;
    {set_wr, set_ch, tbl_wr, tbl_ch, rd_ch, comb_wr, over_temp} = '0;
    {set_val, tbl_idx, rd_idx, tbl_volt, tbl_dly} = '0;
    set_item = tss_pkg::ITEM_EDGE_IN;
    cmd = tss_pkg::CHANNEL_ONE_ON;
    tv = '{default: '0};
    td = '{default: '0};
    e2 = 1'b0;
    cw(8);
    rst = 1'b0;
    cw(4);
    chk("trig_out_idle", trig_out, 2'b11);
    chk("vout_rst", vout_set, 0);
    chk("next_rst", next_step, {5'h01, 5'h01});
    chk("active_rst", trig_active, 0);
    rchk(1'b0, 5'h14, 1'b1);
    $display("test defaults done");
    for (int i = 1; i <= 20; i++) begin
      for (int c = 0; c < 2; c++) twr(c[0], i[4:0], 14'(xs() % 15001), 19'(xs() % 4));
    end
    twr(1'b1, 5'h14, tss_pkg::VOLT_MAX, tss_pkg::DLY_MAX);
    twr(1'b0, 5'h03, 14'h3A99, 19'h0_0001);
    twr(1'b0, 5'h15, 14'h0001, 19'h0_0000);
    for (int i = 0; i <= 21; i++) rchk(i[0], i[4:0], i >= 1 && i <= 20);
    $display("test table done");
    set(1'b0, tss_pkg::ITEM_EDGE_IN, 16'h0001);
    in_rise[0] = 1'b1;
    set(1'b0, tss_pkg::ITEM_VOLT_EN, 16'h0001);
    set(1'b0, tss_pkg::ITEM_MEAS, 16'h0000);
    set(1'b0, tss_pkg::ITEM_STEP_POINT_COUNT, 16'h0003);
    m = seen[0];
    set(1'b0, tss_pkg::ITEM_EXT_EN, 16'h0001);
    wp(0, m[7:0], 1'b1);
    for (int k = 0; k < 5; k++) begin
      trig(0, 1'b1);
      chk("vout_step", vout_set[0], tv[0][k % 3 + 1]);
      chk("next_step", next_step[0], 5'(((k + 1) % 3) + 1));
    end
    chk("no_meas", ms0, 0);
    set(1'b0, tss_pkg::ITEM_EDGE_OUT, 16'h0001);
    out_rise[0] = 1'b1;
    cw(2);
    chk("idle_rise", trig_out[0], 1'b0);
    trig(0, 1'b1);
    $display("test stepping done");
    set(1'b0, tss_pkg::ITEM_MEAS, 16'h0002);
    set(1'b0, tss_pkg::ITEM_STEP_POINT_COUNT, 16'h0002);
    pulse_rearm();
    m = ms0;
    trig(0, 1'b1);
    trig(0, 1'b1);
    trig(0, 1'b0);
    chk("meas_count", ms0 - m, 2);
    pulse_rearm();
    trig(0, 1'b1);
    $display("test rearm done");
    set(1'b0, tss_pkg::ITEM_END_V, 16'h1234);
    set(1'b0, tss_pkg::ITEM_EXT_EN, 16'h0000);
    set(1'b0, tss_pkg::ITEM_END_V, 16'h3A99);
    cw(2);
    chk("end_volt", vout_set[0], 14'h1234);
    chk("off", trig_active[0], 1'b0);
    set(1'b1, tss_pkg::ITEM_DUAL, 16'h0001);
    for (int c = 0; c < 6; c++) begin
      @(negedge clk_sys);
      comb_wr = 1'b1;
      cmd = tss_pkg::tss_comb_e'(c);
      @(negedge clk_sys);
      comb_wr = 1'b0;
      cw(2);
      if (c == 2 || c == 4) e2 = 1'b1;
      if (c == 3 || c == 5) e2 = 1'b0;
      chk("comb", trig_active, {e2, 1'b0});
    end
    set(1'b1, tss_pkg::ITEM_EXT_EN, 16'h0001);
    cw(2);
    chk("own_en_ignored", trig_active[1], 1'b0);
    $display("test combined done");
    @(negedge clk_sys);
    comb_wr = 1'b1;
    cmd = tss_pkg::BOTH_CHANNELS_ON;
    @(negedge clk_sys);
    comb_wr = 1'b0;
    set(1'b0, tss_pkg::ITEM_VPT, 16'h0000);
    set(1'b0, tss_pkg::ITEM_EXT_EN, 16'h0001);
    vpt_trip[0] = 1'b1;
    cw(3);
    chk("vpt_off", trig_active, 2'b11);
    vpt_trip = 2'b10;
    cw(3);
    chk("vpt_trip", trig_active, 2'b00);
    chk("trip_end", vout_set, {14'h0000, 14'h1234});
    vpt_trip = 2'b00;
    set(1'b0, tss_pkg::ITEM_EXT_EN, 16'h0001);
    over_temp = 1'b1;
    cw(3);
    chk("heat_trip", trig_active[0], 1'b0);
    over_temp = 1'b0;
    set(1'b0, tss_pkg::ITEM_EXT_EN, 16'h0001);
    ilim_trip[1] = 1'b1;
    cw(3);
    chk("ilim_trip", trig_active[0], 1'b0);
    ilim_trip = 2'b00;
    $display("test faults done");
    set(1'b0, tss_pkg::ITEM_EXT_EN, 16'h0001);
    @(negedge clk_sys);
    comb_wr = 1'b1;
    cmd = tss_pkg::BOTH_CHANNELS_ON;
    @(negedge clk_sys);
    comb_wr = 1'b0;
    cw(8);
    m = ms0;
    trig(1, 1'b1);
    chk("shared_v0", vout_set[0], tv[0][1]);
    chk("shared_v1", vout_set[1], tv[1][1]);
    set(1'b1, tss_pkg::ITEM_DUAL, 16'h0002);
    trig(1, 1'b1);
    cw(20);
    chk("shared_meas", ms0 - m, 1);
    chk("shared_hold", vout_set[0], tv[0][1]);
    $display("test shared done");
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire
